/* src/dpwm_pkg.sv */
package dpwm_pkg;
	localparam int          ADDR_W         = 3;
	localparam int          DATA_W         = 16;
	localparam int          DUTY_W         = 8;
	localparam int          DIV_W          = 2;
	localparam int          TRIM_W         = 4;
	localparam int          CNT_W          = 10;
	localparam int          DUTY_LSB       = 0;
	localparam int          DIV_LSB        = 8;
	localparam logic [2:0]  GEN0_CTRL_OFS  = 3'h0;
	localparam logic [2:0]  GEN1_CTRL_OFS  = 3'h1;
	localparam logic [2:0]  TRIM_OFS       = 3'h2;
	localparam logic [2:0]  OUT_EN_OFS     = 3'h3;
	localparam logic [2:0]  MAP_OFS        = 3'h4;
	localparam logic [2:0]  STATUS_OFS     = 3'h5;
	localparam logic [9:0]  CTRL_RST       = 10'h000;
	localparam logic [3:0]  TRIM_NOM       = 4'h8;
	localparam logic [3:0]  TRIM_RSVD      = 4'h0;
	localparam logic [7:0]  OUT_EN_RST     = 8'h00;
	localparam logic [15:0] MAP_RST        = 16'h0000;
	localparam logic [1:0]  DIV_1024       = 2'h0;
	localparam logic [1:0]  DIV_512        = 2'h1;
	localparam logic [1:0]  DIV_256        = 2'h2;
	localparam logic [1:0]  DIV_FULL       = 2'h3;
	localparam int          CLK_HZ         = 10000000;
	localparam int          F_INT_HZ       = 102400;
	localparam logic [7:0]  BASE_DIV       = 8'(CLK_HZ / F_INT_HZ);
	localparam logic [7:0]  TRIM_STEP      = 8'h05;
	typedef enum logic [1:0] {SRC_GEN0, SRC_GEN1, SRC_IN0, SRC_IN1} dpwm_src_t;
endpackage

/* src/dpwm_top.sv */
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module dpwm_top
	import dpwm_pkg::*;
#(
	parameter int NCH = 8
) (
	input  wire logic                         clk,
	input  wire logic                         rstn,
	input  wire logic [dpwm_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [dpwm_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [dpwm_pkg::DATA_W-1:0]  reg_rdata,
	input  wire logic [1:0]                   parallel_input_pin,
	output logic      [1:0]                   gen_out,
	output logic      [NCH-1:0]               ch_out
);
	import dpwm_pkg::*;

	logic [9:0]        gen_ctrl_ff [2];
	logic [TRIM_W-1:0] base_rate_trim_ff;
	logic [NCH-1:0]    out_en_ff;
	logic [2*NCH-1:0]  map_ff;
	logic [1:0]        pin_meta_ff;
	logic [1:0]        pin_sync_ff;
	logic [7:0]        tick_cnt_ff;
	logic              tick_ff;
	logic [7:0]        nxt_reload;
	logic [CNT_W-1:0]  cnt_ff [2];
	logic [DUTY_W-1:0] act_duty_ff [2];
	logic [DIV_W-1:0]  act_div_ff [2];
	logic [1:0]        bnd;
	logic [1:0]        gen_out_ff;
	logic [NCH-1:0]    ch_out_ff;
	logic [DATA_W-1:0] reg_rdata_ff;

	function automatic logic [CNT_W-1:0] period_last(input logic [DIV_W-1:0] div);
		case (div)
			DIV_1024: period_last = 10'h3ff;
			DIV_512:  period_last = 10'h1ff;
			default:  period_last = 10'h0ff;
		endcase
	endfunction

	function automatic logic [7:0] scaled_step(input logic [CNT_W-1:0] cnt,
			input logic [DIV_W-1:0] div);
		case (div)
			DIV_1024: scaled_step = cnt[9:2];
			DIV_512:  scaled_step = cnt[8:1];
			default:  scaled_step = cnt[7:0];
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register port. Writes land at once in the shadow settings; the generators
	// only pick them up at their own period boundary, so software may rewrite a
	// generator control word several times in one period and only the last value written before the boundary cycle is used.

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			gen_ctrl_ff[0] <= CTRL_RST;
			gen_ctrl_ff[1] <= CTRL_RST;
		end else if (reg_wr && reg_addr == GEN0_CTRL_OFS) begin
			gen_ctrl_ff[0] <= reg_wdata[9:0];
		end else if (reg_wr && reg_addr == GEN1_CTRL_OFS) begin
			gen_ctrl_ff[1] <= reg_wdata[9:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			base_rate_trim_ff <= TRIM_NOM;
			out_en_ff         <= OUT_EN_RST;
			map_ff            <= MAP_RST;
		end else if (reg_wr) begin
			if (reg_addr == TRIM_OFS) begin
				base_rate_trim_ff <= reg_wdata[TRIM_W-1:0];
			end
			if (reg_addr == OUT_EN_OFS) begin
				out_en_ff <= reg_wdata[NCH-1:0];
			end
			if (reg_addr == MAP_OFS) begin
				map_ff <= reg_wdata[2*NCH-1:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata_ff <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				GEN0_CTRL_OFS: reg_rdata_ff <= {6'h00, gen_ctrl_ff[0]};
				GEN1_CTRL_OFS: reg_rdata_ff <= {6'h00, gen_ctrl_ff[1]};
				TRIM_OFS:      reg_rdata_ff <= {12'h000, base_rate_trim_ff};
				OUT_EN_OFS:    reg_rdata_ff <= {8'h00, out_en_ff};
				MAP_OFS:       reg_rdata_ff <= map_ff;
				STATUS_OFS:    reg_rdata_ff <= {6'h00, gen_out_ff, ch_out_ff};
				default:       reg_rdata_ff <= '0;
			endcase
		end
	end

	assign reg_rdata = reg_rdata_ff;

	////////////////////////////////////////////////////////////////////////////
	// Parallel input pins are asynchronous to clk.

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_meta_ff <= 2'h0;
			pin_sync_ff <= 2'h0;
		end else begin
			pin_meta_ff <= parallel_input_pin;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Base tick. The oscillator is modelled by a clk divider whose reload the
	// trim moves by a fixed step per code, except reserved code 0 which gives the nominal reload; the real trim curve is not linear.

	always_comb begin
		if (base_rate_trim_ff == TRIM_RSVD) begin
			nxt_reload = BASE_DIV;
		end else begin
			nxt_reload = 8'(BASE_DIV - 8'(({4'h0, base_rate_trim_ff} - {4'h0, TRIM_NOM})
				* TRIM_STEP));
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt_ff <= '0;
			tick_ff     <= 1'b0;
		end else if (tick_cnt_ff == 8'h00) begin
			tick_cnt_ff <= 8'(nxt_reload - 8'h01);
			tick_ff     <= 1'b1;
		end else begin
			tick_cnt_ff <= 8'(tick_cnt_ff - 8'h01);
			tick_ff     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Generators.

	default clocking dflt_cb @(posedge clk); endclocking
	default disable iff (!rstn);

	for (genvar g = 0; g < 2; g++) begin : gen_pwm
		assign bnd[g] = tick_ff && cnt_ff[g] == period_last(act_div_ff[g]);

		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				cnt_ff[g] <= '0;
			end else if (bnd[g]) begin
				cnt_ff[g] <= '0;
			end else if (tick_ff) begin
				cnt_ff[g] <= 10'(cnt_ff[g] + 10'h001);
			end
		end

		// Settings are only taken at a boundary so no period is ever cut short.
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				act_duty_ff[g] <= CTRL_RST[DUTY_LSB +: DUTY_W];
				act_div_ff[g]  <= CTRL_RST[DIV_LSB +: DIV_W];
			end else if (bnd[g]) begin
				act_duty_ff[g] <= gen_ctrl_ff[g][DUTY_LSB +: DUTY_W];
				act_div_ff[g]  <= gen_ctrl_ff[g][DIV_LSB +: DIV_W];
			end
		end

		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				gen_out_ff[g] <= 1'b0;
			end else if (act_div_ff[g] == DIV_FULL) begin
				gen_out_ff[g] <= 1'b1;
			end else begin
				gen_out_ff[g] <= scaled_step(cnt_ff[g], act_div_ff[g])
					< act_duty_ff[g];
			end
		end

		AST_SETTLE_AT_BOUNDARY: assert property (!$past(bnd[g]) |->
			$stable(act_duty_ff[g])) else $error("duty changed mid period");
		AST_DIV_AT_BOUNDARY: assert property (!$past(bnd[g]) |->
			$stable(act_div_ff[g])) else $error("divider changed mid period");
		AST_FULL_ON: assert property (act_div_ff[g] == DIV_FULL ##1
			act_div_ff[g] == DIV_FULL |-> gen_out_ff[g]) else $error("full on not high");
		AST_ZERO_LOW: assert property ((act_duty_ff[g] == 8'h00 &&
			act_div_ff[g] != DIV_FULL)[*2] |-> !gen_out_ff[g]) else $error("zero duty high");
		AST_TOP_STEP_LOW: assert property ($past(act_div_ff[g]) != DIV_FULL &&
			$past(scaled_step(cnt_ff[g], act_div_ff[g])) == 8'hff |-> !gen_out_ff[g])
			else $error("last step high");
		AST_DUTY_COMPARE: assert property ($past(act_div_ff[g]) != DIV_FULL |->
			gen_out_ff[g] == ($past(scaled_step(cnt_ff[g], act_div_ff[g]))
			< $past(act_duty_ff[g]))) else $error("duty compare wrong");
		AST_PERIOD_WRAP: assert property (bnd[g] |=> cnt_ff[g] == 10'h000 &&
			$past(cnt_ff[g]) == period_last($past(act_div_ff[g])))
			else $error("period wrap wrong");

		// The period counter may only move on a base tick. A stray advance
		// between ticks would stretch the duty compare and cut the period short.
		AST_CNT_HOLD: assert property (!tick_ff |=> $stable(cnt_ff[g]))
			else $error("period counter moved without tick");
		AST_CNT_STEP: assert property (tick_ff && !bnd[g] |=>
			cnt_ff[g] == 10'($past(cnt_ff[g]) + 10'h001))
			else $error("period counter step wrong");
		AST_SETTLE_TAKE: assert property (bnd[g] |=>
			act_duty_ff[g] == $past(gen_ctrl_ff[g][DUTY_LSB +: DUTY_W]))
			else $error("duty not taken at boundary");
		AST_DIV_TAKE: assert property (bnd[g] |=>
			act_div_ff[g] == $past(gen_ctrl_ff[g][DIV_LSB +: DIV_W]))
			else $error("divider not taken at boundary");

		COV_FULL_ON: cover property (act_div_ff[g] == DIV_FULL && gen_out_ff[g]);
		COV_NEW_DIV: cover property (bnd[g] ##1 $changed(act_div_ff[g]));
		COV_NEW_DUTY: cover property (bnd[g] ##1 $changed(act_duty_ff[g]));
	end

	assign gen_out = gen_out_ff;

	////////////////////////////////////////////////////////////////////////////
	// Channel mapping: two bits per channel pick one of four groups.

	for (genvar c = 0; c < NCH; c++) begin : gen_ch
		dpwm_src_t src;
		logic      sel;

		assign src = dpwm_src_t'(map_ff[2*c +: 2]);

		always_comb begin
			case (src)
				SRC_GEN0: sel = gen_out_ff[0];
				SRC_GEN1: sel = gen_out_ff[1];
				SRC_IN0:  sel = pin_sync_ff[0];
				SRC_IN1:  sel = pin_sync_ff[1];
				default:  sel = 1'b0;
			endcase
		end

		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				ch_out_ff[c] <= 1'b0;
			end else begin
				ch_out_ff[c] <= out_en_ff[c] && sel;
			end
		end

		// A disabled channel must stay off whatever its group is doing.
		AST_CH_OFF: assert property (!$past(out_en_ff[c]) |-> !ch_out_ff[c])
			else $error("disabled channel driven");
	end

	assign ch_out = ch_out_ff;

	AST_MAP_GEN1: assert property ($past(out_en_ff[0]) &&
		$past(map_ff[1:0]) == 2'h1 |-> ch_out_ff[0] == $past(gen_out_ff[1]))
		else $error("channel not following generator 1");
	AST_MAP_PIN: assert property ($past(out_en_ff[1]) &&
		$past(map_ff[3:2]) == 2'h3 |-> ch_out_ff[1] == $past(pin_sync_ff[1]))
		else $error("channel not following input pin 1");
	AST_GEN_INDEPENDENT: assert property (reg_wr && reg_addr == GEN0_CTRL_OFS |=>
		$stable(gen_ctrl_ff[1])) else $error("generator 1 setting disturbed");
	AST_TICK_SPACING: assert property (tick_ff |=> !tick_ff)
		else $error("base tick too fast");
	AST_GEN1_INDEPENDENT: assert property (reg_wr && reg_addr == GEN1_CTRL_OFS |=>
		$stable(gen_ctrl_ff[0])) else $error("generator 0 setting disturbed");
	AST_READ_LATENCY: assert property (reg_rd && reg_addr == TRIM_OFS |=>
		reg_rdata == {12'h000, $past(base_rate_trim_ff)}) else $error("read data wrong");

	// Every tick reloads the divider from the trim in force one cycle before,
	// so a trim write never produces a runt or stretched tick beyond one reload.
	AST_TICK_RELOAD: assert property (tick_ff |->
		tick_cnt_ff == 8'($past(nxt_reload) - 8'h01)) else $error("tick reload wrong");
	AST_TRIM_RESERVED: assert property (base_rate_trim_ff == TRIM_RSVD |->
		nxt_reload == BASE_DIV) else $error("reserved trim not nominal");

	// Pins reach the channel logic only through both synchroniser stages.
	AST_PIN_SYNC: assert property ($past(rstn, 2) |->
		pin_sync_ff == $past(parallel_input_pin, 2)) else $error("pin sync depth wrong");
	COV_PIN_GROUP: cover property (out_en_ff[0] && map_ff[1:0] == 2'h2 && ch_out_ff[0]);
endmodule
`default_nettype wire

/* bench/dpwm_load_model.sv */
`timescale 1ns/1ns
`default_nettype none
module dpwm_load_model #(
	parameter int NCH = 8
) (
	input  wire logic           clk,
	input  wire logic           rstn,
	input  wire logic [NCH-1:0] ch_out,
	output logic      [15:0]    rise_cnt
);
	logic        ch0_ff;
	logic [15:0] rise_cnt_ff;
	// The load only sees switch closures, so it counts turn-ons on channel 0.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ch0_ff      <= 1'b0;
			rise_cnt_ff <= 16'h0000;
		end else begin
			ch0_ff <= ch_out[0];
			if (ch_out[0] && !ch0_ff) begin
				rise_cnt_ff <= rise_cnt_ff + 16'h0001;
			end
		end
	end
	assign rise_cnt = rise_cnt_ff;
endmodule
`default_nettype wire

/* bench/tb_dpwm_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_dpwm_top;
	import dpwm_pkg::*;
	logic              clk;
	logic              rstn;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [DATA_W-1:0] reg_rdata;
	logic [1:0]        pin;
	logic [1:0]        gen_out;
	logic [7:0]        ch_out;
	logic [15:0]       rise_cnt;
	logic [1:0]        g_prev;
	logic [1:0]        pin_h [3];
	int                n_mismatch;
	int                compares;
	int                seed;
	int                cyc;
	int                hi;
	int                tot;
	int                r;

	dpwm_top #(.NCH(8)) dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.parallel_input_pin(pin), .gen_out(gen_out), .ch_out(ch_out));
	dpwm_load_model #(.NCH(8)) load (.clk(clk), .rstn(rstn), .ch_out(ch_out),
		.rise_cnt(rise_cnt));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic conclude();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Base tick length in clocks for a trim code other than reserved 0; the long periods scale with it.
	function automatic int tick_len(input int t);
		return int'(BASE_DIV) - (t - int'(TRIM_NOM)) * int'(TRIM_STEP);
	endfunction

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// Measures one generator 0 period from a rising edge, writing gen 0 control at wr_at.
	task automatic meas(input int wr_at, input logic [15:0] wdat);
		hi  = 1;
		tot = 1;
		for (int i = 0; i < 30000; i++) begin
			@(posedge clk);
			pin       <= 2'($random(seed));
			reg_addr  <= GEN0_CTRL_OFS;
			reg_wdata <= wdat;
			reg_wr    <= (i == wr_at);
			#1;
			check({14'h0, ch_out[3:2]}, {14'h0, pin_h[2]});
			check({12'h0, ch_out[7:6], ch_out[4], ch_out[0]}, {15'h0, g_prev[0]});
			check({14'h0, ch_out[5], ch_out[1]}, {14'h0, g_prev[1], g_prev[1]});
			check({15'h0, gen_out[1]}, 16'h0001);
			pin_h[2] = pin_h[1];
			pin_h[1] = pin_h[0];
			pin_h[0] = pin;
			if (gen_out[0] && !g_prev[0]) begin
				break;
			end
			g_prev = gen_out;
			tot++;
			hi += int'(gen_out[0]);
		end
		g_prev = gen_out;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 99000) begin
			n_mismatch++;
			conclude();
		end
	end

	initial begin
		logic [15:0] d;
		n_mismatch = 0;
		compares   = 0;
		cyc        = 0;
		seed       = 32'h61c6;
		rstn       = 1'b0;
		reg_addr   = 3'h0;
		reg_wdata  = 16'h0000;
		reg_wr     = 1'b0;
		reg_rd     = 1'b0;
		pin        = 2'h0;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rd(TRIM_OFS, d);
		check(d, 16'h0008);
		rd(GEN0_CTRL_OFS, d);
		check(d, 16'h0000);
		wr(3'h7, 16'hffff);
		rd(3'h7, d);
		check(d, 16'h0000);
		wr(TRIM_OFS, 16'h000f);
		rd(TRIM_OFS, d);
		check(d, 16'h000f);
		r = tick_len(15);
		wr(GEN0_CTRL_OFS, {6'h0, DIV_256, 8'h80});
		wr(GEN1_CTRL_OFS, {6'h0, DIV_FULL, 8'h00});
		wr(MAP_OFS, 16'h04e4);
		wr(OUT_EN_OFS, 16'h002f);
		rd(GEN1_CTRL_OFS, d);
		check(d, 16'h0300);
		@(posedge clk);
		pin <= 2'($random(seed));
		for (int i = 0; i < 70000; i++) begin
			@(posedge clk);
			#1;
			if (gen_out[1]) begin
				break;
			end
			check({14'h0, gen_out}, 16'h0000);
		end
		check({15'h0, gen_out[0]}, 16'h0001);
		g_prev = gen_out;
		pin_h  = '{pin, pin, pin};
		meas(100, {6'h0, DIV_256, 8'hff});
		check(16'(hi), 16'(128 * r));
		check(16'(tot), 16'(256 * r));
		meas(-1, 16'h0000);
		check(16'(hi), 16'(255 * r));
		check(16'(tot), 16'(256 * r));
		repeat (2) @(posedge clk);
		#1;
		check(rise_cnt, 16'h0003);
		rd(STATUS_OFS, d);
		check({14'h0, d[9:8]}, 16'h0003);
		conclude();
	end
endmodule
`default_nettype wire
